// ==== rtl/dmc_map.svh ====
// register offsets, field positions, reset values and constants of the dma core
// assumes a byte-addressed register slave decoding eight address bits
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
`define DMC_NCH          4
`define DMC_REG_CTRL     8'h00
`define DMC_REG_BASE     8'h04
`define DMC_REG_WRB      8'h08
`define DMC_REG_SWTRIG   8'h0C
`define DMC_REG_ISTAT    8'h10
`define DMC_REG_IMASK    8'h14
`define DMC_REG_CRCDATA  8'h18
`define DMC_REG_CRCSUM   8'h1C
`define DMC_PAGE_CHCFG   4'h2
`define DMC_PAGE_CHSTAT  4'h3
`define DMC_CTRL_EN      0
`define DMC_CTRL_CRCMODE 1
`define DMC_CTRL_CRCSRC  4
`define DMC_CH_EN        0
`define DMC_CH_ENDSUSP   1
`define DMC_CH_BURST     2
`define DMC_CH_PRIO      5
`define DMC_CH_TRIG      8
`define DMC_CH_WMASK     16'h3F7F
`define DMC_BT_VALID     0
`define DMC_BT_BLKINT    1
`define DMC_BT_BLKEVT    2
`define DMC_BT_BEATEVT   3
`define DMC_BT_SIZE      4
`define DMC_BT_SRCINC    6
`define DMC_BT_DSTINC    7
`define DMC_TRIG_SW      6'h00
`define DMC_TRIG_EVT     6'h01
`define DMC_DESC_BYTES   6
`define DMC_BLOCK_MAX    17'h1_0000
`define DMC_CRC16_POLY   16'h1021
`define DMC_CRC32_POLY   32'hEDB8_8320
`define DMC_CRC_RST      32'hFFFF_FFFF
`endif

// ==== rtl/dmc_pkg.sv ====
// types of the dma core: engine states and the full register state record
// assumes dmc_map.svh is on the include path
`include "dmc_map.svh"
package dmc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_RD, ST_WR} dmc_state_e;
	typedef struct packed {
		dmc_state_e                     st;
		logic [1:0]                     ch;
		logic [1:0]                     widx;
		logic [2:0]                     bcnt;
		logic [`DMC_NCH-1:0][15:0]      chcfg;
		logic [`DMC_NCH-1:0]            pend;
		logic [`DMC_NCH-1:0]            busy;
		logic [`DMC_NCH-1:0]            susp;
		logic [`DMC_NCH-1:0]            nfetch;
		logic [`DMC_NCH-1:0][15:0]      btctl;
		logic [`DMC_NCH-1:0][16:0]      rem;
		logic [`DMC_NCH-1:0][31:0]      src;
		logic [`DMC_NCH-1:0][31:0]      dst;
		logic [`DMC_NCH-1:0][31:0]      nxt;
		logic [6:0]                     ctrl;
		logic [31:0]                    base;
		logic [31:0]                    wrb;
		logic [`DMC_NCH-1:0]            istat;
		logic [`DMC_NCH-1:0]            imask;
		logic [31:0]                    crc;
		logic                           s_wait;
		logic [31:0]                    s_rdata;
		logic [31:0]                    m_addr;
		logic                           m_rd;
		logic                           m_wr;
		logic [31:0]                    m_wdata;
		logic [3:0]                     m_be;
		logic [`DMC_NCH-1:0]            beat_evt;
		logic [`DMC_NCH-1:0]            blk_evt;
		logic                           irq;
	} dmc_regs_s;
endpackage

// ==== rtl/dmc_core.sv ====
// multichannel dma engine: register slave, arbiter, descriptor walker, crc unit
// assumes memories on an avalon-mm master port and triggers from logic on clk
`timescale 1ns/100ps
`include "dmc_map.svh"

module dmc_core (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic [7:0]          s_address,
	input  wire logic                s_read,
	input  wire logic                s_write,
	input  wire logic [31:0]         s_writedata,
	input  wire logic [3:0]          s_byteenable,
	output logic      [31:0]         s_readdata,
	output logic                     s_waitrequest,
	output logic      [31:0]         m_address,
	output logic                     m_read,
	output logic                     m_write,
	output logic      [31:0]         m_writedata,
	output logic      [3:0]          m_byteenable,
	input  wire logic [31:0]         m_readdata,
	input  wire logic                m_waitrequest,
	input  wire logic [`DMC_NCH-1:0] evt_trig,
	input  wire logic [63:0]         periph_trig,
	output logic      [`DMC_NCH-1:0] beat_evt,
	output logic      [`DMC_NCH-1:0] block_evt,
	output logic                     irq
);
	dmc_pkg::dmc_regs_s r;
	dmc_pkg::dmc_regs_s n;

	function automatic logic [31:0] bmerge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [3:0] szmask(input logic [1:0] sz);
		case (sz)
			2'd0:    szmask = 4'h1;
			2'd1:    szmask = 4'h3;
			default: szmask = 4'hF;
		endcase
	endfunction

	// bytes go in low lane first; crc16 shifts msb first, crc32 is the reflected form
	function automatic logic [31:0] crc_feed(
		input logic [31:0] crc,
		input logic [31:0] data,
		input logic [3:0]  lanes,
		input logic        mode32
	);
		logic [31:0] c;
		logic        fb;
		c = crc;
		fb = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				for (int b = 0; b < 8; b++) begin
					if (mode32) begin
						fb = c[0] ^ data[8*i + b];
						c = {1'b0, c[31:1]} ^ (fb ? `DMC_CRC32_POLY : 32'h0000_0000);
					end else begin
						fb = c[15] ^ data[8*i + 7 - b];
						c[15:0] = {c[14:0], 1'b0} ^ (fb ? `DMC_CRC16_POLY : 16'h0000);
					end
				end
			end
		end
		return c;
	endfunction

	// per-channel trigger selection and request
	logic [`DMC_NCH-1:0] trig;
	logic [`DMC_NCH-1:0] req;
	genvar g;
	generate
		for (g = 0; g < `DMC_NCH; g++) begin : gch
			logic [5:0] sel;
			assign sel = r.chcfg[g][`DMC_CH_TRIG +: 6];
			// codes from 0x02 up index the peripheral lines directly
			assign trig[g] = (sel == `DMC_TRIG_SW)  ? 1'b0 :
			                 (sel == `DMC_TRIG_EVT) ? evt_trig[g] :
			                 periph_trig[sel];
			assign req[g] = r.chcfg[g][`DMC_CH_EN] & ~r.susp[g] & (r.pend[g] | r.busy[g]);
		end
	endgenerate

	always_comb begin
		logic [`DMC_NCH-1:0] swset;
		logic [1:0]          win;
		logic [1:0]          bestp;
		logic [1:0]          c;
		logic [1:0]          sz;
		logic [31:0]         step;
		logic [31:0]         beat;
		logic [31:0]         rdmux;
		logic [15:0]         cfg;
		logic [1:0]          ri;
		n = r;
		// register channel index, kept apart from c so an access never steers the engine
		ri = 2'd0;
		swset = '0;
		win = 2'd0;
		bestp = 2'd0;
		c = r.ch;
		cfg = r.chcfg[r.ch];
		sz = r.btctl[r.ch][`DMC_BT_SIZE +: 2];
		step = {29'd0, (sz == 2'd0) ? 3'd1 : (sz == 2'd1) ? 3'd2 : 3'd4};
		beat = m_readdata >> {r.src[r.ch][1:0], 3'b000};
		n.beat_evt = '0;
		n.blk_evt = '0;

		// register read mux
		rdmux = 32'h0000_0000;
		case (s_address)
			`DMC_REG_CTRL:    rdmux = {25'd0, r.ctrl};
			`DMC_REG_BASE:    rdmux = r.base;
			`DMC_REG_WRB:     rdmux = r.wrb;
			`DMC_REG_ISTAT:   rdmux = {28'd0, r.istat};
			`DMC_REG_IMASK:   rdmux = {28'd0, r.imask};
			`DMC_REG_CRCSUM:  rdmux = r.crc;
			default: begin
				if (s_address[7:4] == `DMC_PAGE_CHCFG) begin
					rdmux = {16'd0, r.chcfg[s_address[3:2]]};
				end else if (s_address[7:4] == `DMC_PAGE_CHSTAT) begin
					ri = s_address[3:2];
					rdmux = {r.pend[ri], r.busy[ri], r.susp[ri], r.nfetch[ri], 11'd0, r.rem[ri]};
				end
			end
		endcase

		// slave: waitrequest high one cycle, then the access completes
		if ((s_read | s_write) && r.s_wait) begin
			n.s_wait = 1'b0;
			n.s_rdata = s_read ? rdmux : 32'h0000_0000;
		end else if ((s_read | s_write) && !r.s_wait) begin
			n.s_wait = 1'b1;
			if (s_write) begin
				case (s_address)
					`DMC_REG_CTRL: begin
						n.ctrl = 7'(bmerge({25'd0, r.ctrl}, s_writedata, s_byteenable));
					end
					`DMC_REG_BASE: begin
						if (!r.ctrl[`DMC_CTRL_EN]) begin
							n.base = bmerge(r.base, s_writedata, s_byteenable);
						end
					end
					`DMC_REG_WRB: begin
						if (!r.ctrl[`DMC_CTRL_EN]) begin
							n.wrb = bmerge(r.wrb, s_writedata, s_byteenable);
						end
					end
					`DMC_REG_SWTRIG: begin
						if (s_byteenable[0]) begin
							swset = s_writedata[`DMC_NCH-1:0];
						end
					end
					`DMC_REG_ISTAT: begin
						if (s_byteenable[0]) begin
							n.istat = r.istat & ~s_writedata[`DMC_NCH-1:0];
						end
					end
					`DMC_REG_IMASK: begin
						if (s_byteenable[0]) begin
							n.imask = s_writedata[`DMC_NCH-1:0];
						end
					end
					`DMC_REG_CRCDATA: begin
						if (r.ctrl[`DMC_CTRL_CRCSRC +: 3] == 3'd0) begin
							n.crc = crc_feed(r.crc, s_writedata, s_byteenable,
								r.ctrl[`DMC_CTRL_CRCMODE]);
						end
					end
					`DMC_REG_CRCSUM: begin
						n.crc = bmerge(r.crc, s_writedata, s_byteenable);
					end
					default: begin
						if (s_address[7:4] == `DMC_PAGE_CHCFG) begin
							ri = s_address[3:2];
							n.chcfg[ri] = 16'(bmerge({16'd0, r.chcfg[ri]}, s_writedata,
								s_byteenable)) & `DMC_CH_WMASK;
							// a fresh write releases a suspended channel
							n.susp[ri] = 1'b0;
						end
					end
				endcase
			end
		end

		// engine
		case (r.st)
			dmc_pkg::ST_IDLE: begin
				if (r.ctrl[`DMC_CTRL_EN] && (|req)) begin
					// scan downward with >= so a tie lands on the lowest channel
					for (int i = `DMC_NCH - 1; i >= 0; i--) begin
						if (req[i] && (r.chcfg[i][`DMC_CH_PRIO +: 2] >= bestp)) begin
							bestp = r.chcfg[i][`DMC_CH_PRIO +: 2];
							win = 2'(i);
						end
					end
					n.ch = win;
					n.bcnt = 3'd0;
					if (!r.busy[win]) begin
						n.busy[win] = 1'b1;
						n.pend[win] = 1'b0;
						n.nfetch[win] = 1'b0;
						n.m_addr = r.base + {26'd0, win, 4'h0};
						n.m_rd = 1'b1;
						n.m_be = 4'hF;
						n.widx = 2'd0;
						n.st = dmc_pkg::ST_FETCH;
					end else if (r.nfetch[win]) begin
						n.m_addr = r.nxt[win];
						n.m_rd = 1'b1;
						n.m_be = 4'hF;
						n.widx = 2'd0;
						n.st = dmc_pkg::ST_FETCH;
					end else begin
						// resume where the block stopped
						n.m_addr = r.src[win];
						n.m_rd = 1'b1;
						n.m_be = szmask(r.btctl[win][`DMC_BT_SIZE +: 2]) << r.src[win][1:0];
						n.st = dmc_pkg::ST_RD;
					end
				end
			end
			dmc_pkg::ST_FETCH: begin
				if (!m_waitrequest) begin
					case (r.widx)
						2'd0: begin
							n.btctl[c] = m_readdata[15:0];
							// zero count stands for the full 64k beats
							n.rem[c] = (m_readdata[31:16] == 16'h0000) ? `DMC_BLOCK_MAX :
								{1'b0, m_readdata[31:16]};
						end
						2'd1:    n.src[c] = m_readdata;
						2'd2:    n.dst[c] = m_readdata;
						default: n.nxt[c] = m_readdata;
					endcase
					n.widx = r.widx + 2'd1;
					n.m_addr = r.m_addr + 32'h0000_0004;
					if (r.widx == 2'd3) begin
						n.m_rd = 1'b0;
						n.m_be = 4'h0;
						n.nfetch[c] = 1'b0;
						n.st = dmc_pkg::ST_IDLE;
						if (!r.btctl[c][`DMC_BT_VALID]) begin
							// an invalid descriptor closes the transaction
							n.busy[c] = 1'b0;
							n.susp[c] = cfg[`DMC_CH_ENDSUSP];
							n.chcfg[c][`DMC_CH_EN] = cfg[`DMC_CH_ENDSUSP];
						end
					end
				end
			end
			dmc_pkg::ST_RD: begin
				if (!m_waitrequest) begin
					n.m_rd = 1'b0;
					n.m_wr = 1'b1;
					n.m_addr = r.dst[c];
					n.m_be = szmask(sz) << r.dst[c][1:0];
					n.m_wdata = beat << {r.dst[c][1:0], 3'b000};
					if (r.ctrl[`DMC_CTRL_CRCSRC +: 3] == {1'b0, c} + 3'd1) begin
						n.crc = crc_feed(r.crc, beat, szmask(sz),
							r.ctrl[`DMC_CTRL_CRCMODE]);
					end
					n.st = dmc_pkg::ST_WR;
				end
			end
			dmc_pkg::ST_WR: begin
				if (!m_waitrequest) begin
					n.m_wr = 1'b0;
					n.m_be = 4'h0;
					if (r.btctl[c][`DMC_BT_SRCINC]) begin
						n.src[c] = r.src[c] + step;
					end
					if (r.btctl[c][`DMC_BT_DSTINC]) begin
						n.dst[c] = r.dst[c] + step;
					end
					n.rem[c] = r.rem[c] - 17'd1;
					n.beat_evt[c] = r.btctl[c][`DMC_BT_BEATEVT];
					n.bcnt = r.bcnt + 3'd1;
					if (r.rem[c] == 17'd1) begin
						n.blk_evt[c] = r.btctl[c][`DMC_BT_BLKEVT];
						n.st = dmc_pkg::ST_IDLE;
						if (r.nxt[c] != 32'h0000_0000) begin
							n.nfetch[c] = 1'b1;
						end else begin
							n.busy[c] = 1'b0;
							n.susp[c] = cfg[`DMC_CH_ENDSUSP];
							n.chcfg[c][`DMC_CH_EN] = cfg[`DMC_CH_ENDSUSP];
						end
					end else if (r.bcnt == cfg[`DMC_CH_BURST +: 3]) begin
						// burst done: back to idle, where another channel may win, as at a block end or after a fetch
						n.st = dmc_pkg::ST_IDLE;
					end else begin
						n.m_rd = 1'b1;
						n.m_addr = r.btctl[c][`DMC_BT_SRCINC] ? r.src[c] + step : r.src[c];
						n.m_be = szmask(sz) <<
							(r.btctl[c][`DMC_BT_SRCINC] ? r.src[c][1:0] + step[1:0] :
							r.src[c][1:0]);
						n.st = dmc_pkg::ST_RD;
					end
				end
			end
			default: begin
				n.st = dmc_pkg::ST_IDLE;
			end
		endcase

		// hardware sets land after clears so a same-cycle event is kept
		for (int i = 0; i < `DMC_NCH; i++) begin
			if (n.chcfg[i][`DMC_CH_EN] && !n.susp[i] && (trig[i] || swset[i])) begin
				n.pend[i] = 1'b1;
			end
			if (n.blk_evt[i] || ((r.st == dmc_pkg::ST_WR) && !m_waitrequest &&
				(c == 2'(i)) && (r.rem[i] == 17'd1))) begin
				if (r.btctl[i][`DMC_BT_BLKINT]) begin
					n.istat[i] = 1'b1;
				end
			end
		end
		n.irq = |(n.istat & n.imask);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
			r.s_wait <= 1'b1;
			r.crc <= `DMC_CRC_RST;
		end else begin
			r <= n;
		end
	end

	assign s_readdata = r.s_rdata;
	assign s_waitrequest = r.s_wait;
	assign m_address = r.m_addr;
	assign m_read = r.m_rd;
	assign m_write = r.m_wr;
	assign m_writedata = r.m_wdata;
	assign m_byteenable = r.m_be;
	assign beat_evt = r.beat_evt;
	assign block_evt = r.blk_evt;
	assign irq = r.irq;
endmodule

// ==== verification/dmc_core_assertions.sv ====
// port assertions of the dma core: slave and master handshakes, event timing
// assumes binding into dmc_core; sees only that module's ports
`timescale 1ns/100ps
module dmc_core_chk (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [7:0]  s_address,
	input wire logic        s_read,
	input wire logic        s_write,
	input wire logic [31:0] s_writedata,
	input wire logic [3:0]  s_byteenable,
	input wire logic [31:0] s_readdata,
	input wire logic        s_waitrequest,
	input wire logic [31:0] m_address,
	input wire logic        m_read,
	input wire logic        m_write,
	input wire logic [31:0] m_writedata,
	input wire logic [3:0]  m_byteenable,
	input wire logic [31:0] m_readdata,
	input wire logic        m_waitrequest,
	input wire logic [3:0]  evt_trig,
	input wire logic [63:0] periph_trig,
	input wire logic [3:0]  beat_evt,
	input wire logic [3:0]  block_evt,
	input wire logic        irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	property p_slv_ans; (s_read || s_write) && s_waitrequest |=> !s_waitrequest; endproperty
	a_slv_ans: assert property (p_slv_ans) else $error("slave answer missing");
	property p_slv_one; !s_waitrequest |=> s_waitrequest; endproperty
	a_slv_one: assert property (p_slv_one) else $error("slave answer too long");
	// a memory that stalls must see the whole request unchanged
	property p_m_hold;
		(m_read || m_write) && m_waitrequest |=>
			$stable({m_read, m_write, m_address, m_writedata, m_byteenable});
	endproperty
	a_m_hold: assert property (p_m_hold) else $error("master request moved");
	property p_m_excl; !(m_read && m_write); endproperty
	a_m_excl: assert property (p_m_excl) else $error("read and write together");
	property p_beat; |beat_evt |-> $past(m_write && !m_waitrequest); endproperty
	a_beat: assert property (p_beat) else $error("beat event without write");
	property p_blk; |block_evt |-> $past(m_write && !m_waitrequest); endproperty
	a_blk: assert property (p_blk) else $error("block event without write");
	property p_one; $onehot0(beat_evt) && $onehot0(block_evt); endproperty
	a_one: assert property (p_one) else $error("two channels active");
	property p_be; m_write |-> m_byteenable inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
	endproperty
	a_be: assert property (p_be) else $error("lane mask not a beat");
	c_beat: cover property (|beat_evt);
	c_blk: cover property (|block_evt);
	c_irq: cover property ($rose(irq));
endmodule

bind dmc_core dmc_core_chk u_chk (.*);

// ==== verification/dmc_mem_model.sv ====
// system memory on the dma master port, with random wait states
// assumes byte memory of 4 kbyte mirrored over the address space
`timescale 1ns/100ps
module dmc_mem_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [31:0] m_address,
	input  wire logic        m_read,
	input  wire logic        m_write,
	input  wire logic [31:0] m_writedata,
	input  wire logic [3:0]  m_byteenable,
	output logic      [31:0] m_readdata,
	output logic             m_waitrequest
);
	logic [7:0]  mem [0:4095];
	int          dly;
	wire  [11:0] a = {m_address[11:2], 2'b00};
	initial for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			m_waitrequest <= 1'b1;
			m_readdata <= 32'h0000_0000;
			dly <= 0;
		end else if ((m_read || m_write) && m_waitrequest) begin
			if (dly == 0) begin
				m_waitrequest <= 1'b0;
				dly <= $urandom_range(3, 0);
				if (m_read) m_readdata <= {mem[a + 3], mem[a + 2], mem[a + 1], mem[a]};
			end else dly <= dly - 1;
		end else begin
			if (m_write && !m_waitrequest)
				for (int i = 0; i < 4; i++)
					if (m_byteenable[i]) mem[a + i] <= m_writedata[8*i +: 8];
			m_waitrequest <= 1'b1;
			// data is not held after the answer, so a late sample shows up
			m_readdata <= ~m_readdata;
		end
	end
endmodule

// ==== verification/dmc_core_tb.sv ====
// self-checking bench of the dma core: registers, crc, chained and arbitrated transfers
// assumes dmc_core, dmc_mem_model and the bound checker are compiled before it
`timescale 1ns/100ps
`include "dmc_map.svh"
module dmc_core_tb;
	logic        clk, rstn, s_read, s_write, s_waitrequest, irq, m_read, m_write, m_waitrequest;
	logic [7:0]  s_address;
	logic [31:0] s_writedata, s_readdata, m_address, m_writedata, m_readdata, q, d, crc;
	logic [3:0]  s_byteenable, m_byteenable, evt_trig, beat_evt, block_evt;
	logic [63:0] periph_trig;
	logic [7:0]  exp_mem [int];
	// ch0, ch1, ch2 slots, then the second link of ch0's chain, which is also ch3's slot
	logic [31:0] dsc [16] = '{32'h0003_00EF, 32'h0000_0200, 32'h0000_0300, 32'h0000_0130,
		32'h0004_00C9, 32'h0000_0400, 32'h0000_0501, 32'h0000_0000,
		32'h0002_00E9, 32'h0000_0600, 32'h0000_0700, 32'h0000_0000,
		32'h0002_00EF, 32'h0000_020C, 32'h0000_030C, 32'h0000_0000};
	int          err_total, checked, first_ch;
	int          beats [4], blocks [4];
	dmc_core dut (.*);
	dmc_mem_model mem_i (.*);
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		for (int c = 0; c < 4; c++) begin
			if (beat_evt[c] === 1'b1 && first_ch < 0) first_ch = c;
			beats[c] += (beat_evt[c] === 1'b1);
			blocks[c] += (block_evt[c] === 1'b1);
		end
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_mem();
		foreach (exp_mem[a]) chk({24'h00_0000, mem_i.mem[a]}, {24'h00_0000, exp_mem[a]});
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		s_address <= a;
		s_writedata <= wd;
		s_write <= wr;
		s_read <= !wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (s_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) err_total++;
		q = s_readdata;
		s_write <= 1'b0;
		s_read <= 1'b0;
	endtask
	task automatic copy(input int s, input int t, input int n);
		for (int i = 0; i < n; i++) exp_mem[t + i] = mem_i.mem[s + i];
	endtask
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b,
		input logic m32);
		if (m32) c = c ^ {24'h00_0000, b};
		else c[15:8] = c[15:8] ^ b;
		for (int i = 0; i < 8; i++)
			if (m32) c = c[0] ? (c >> 1) ^ `DMC_CRC32_POLY : c >> 1;
			else c[15:0] = c[15] ? {c[14:0], 1'b0} ^ `DMC_CRC16_POLY : {c[14:0], 1'b0};
		return c;
	endfunction
	initial begin
		rstn = 1'b0;
		{s_read, s_write, s_address, s_writedata, evt_trig, periph_trig} = '0;
		s_byteenable = 4'hF;
		err_total = 0;
		checked = 0;
		first_ch = -1;
		beats = '{default: 0};
		blocks = '{default: 0};
		void'($urandom(85));
		repeat (3) @(posedge clk);
		chk({s_waitrequest, irq, m_read, m_write, beat_evt, block_evt}, 32'h0000_0800);
		for (int i = 0; i < 16; i++) for (int j = 0; j < 4; j++)
			mem_i.mem[12'h100 + 4*i + j] = dsc[i][8*j +: 8];
		for (int i = 0; i < 32; i++) begin
			mem_i.mem[12'h200 + i] = $urandom;
			mem_i.mem[12'h400 + i] = $urandom;
			mem_i.mem[12'h600 + i] = $urandom;
		end
		rstn <= 1'b1;
		bus(0, `DMC_REG_CRCSUM, 0);
		chk(q, `DMC_CRC_RST);
		for (int m = 0; m < 2; m++) begin
			d = $urandom;
			crc = `DMC_CRC_RST;
			bus(1, `DMC_REG_CRCSUM, crc);
			bus(1, `DMC_REG_CTRL, {30'h0, m[0], 1'b0});
			bus(1, `DMC_REG_CRCDATA, d);
			for (int i = 0; i < 4; i++) crc = crc_byte(crc, d[8*i +: 8], m[0]);
			bus(0, `DMC_REG_CRCSUM, 0);
			d = m ? 32'hFFFF_FFFF : 32'h0000_FFFF;
			chk(q & d, crc & d);
		end
		bus(1, `DMC_REG_BASE, 32'h0000_0100);
		bus(1, `DMC_REG_WRB, 32'h0000_0800);
		bus(1, `DMC_REG_CTRL, 32'h0000_0001);
		bus(1, `DMC_REG_BASE, 32'h0000_0AA0);
		bus(1, `DMC_REG_WRB, 32'h0000_0AA0);
		bus(0, `DMC_REG_BASE, 0);
		chk(q, 32'h0000_0100);
		bus(0, `DMC_REG_WRB, 0);
		chk(q, 32'h0000_0800);
		bus(0, 8'hFC, 0);
		chk(q, 32'h0000_0000);
		// two-beat bursts over a chain of a 3-beat and a 2-beat block
		copy(12'h200, 12'h300, 20);
		bus(1, `DMC_REG_IMASK, 32'h0000_0001);
		bus(1, 8'h20, 32'h0000_0005);
		bus(1, `DMC_REG_SWTRIG, 32'h0000_0001);
		for (int i = 0; i < 4000 && blocks[0] < 2; i++) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(beats[0], 5);
		chk(blocks[0], 2);
		chk_mem();
		chk(irq, 1);
		bus(0, 8'h30, 0);
		chk(q & 32'h6000_0000, 0);
		bus(1, `DMC_REG_IMASK, 0);
		bus(0, `DMC_REG_ISTAT, 0);
		chk(q, 1);
		chk(irq, 0);
		bus(1, `DMC_REG_IMASK, 1);
		bus(0, `DMC_REG_ISTAT, 0);
		chk(irq, 1);
		bus(1, `DMC_REG_ISTAT, 1);
		bus(0, `DMC_REG_ISTAT, 0);
		chk(q, 0);
		chk(irq, 0);
		// ch3 outranks ch0: it takes over only once ch0's first two-beat burst is done
		beats = '{default: 0};
		blocks = '{default: 0};
		bus(1, 8'h2C, 32'h0000_0161);
		bus(1, 8'h20, 32'h0000_0005);
		bus(1, `DMC_REG_SWTRIG, 32'h0000_0001);
		for (int i = 0; i < 4000 && beats[0] < 1; i++) @(posedge clk);
		evt_trig[3] <= 1'b1;
		@(posedge clk);
		evt_trig <= '0;
		for (int i = 0; i < 4000 && blocks[3] < 1; i++) @(posedge clk);
		chk(beats[0], 2);
		for (int i = 0; i < 4000 && blocks[0] < 2; i++) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(beats[0], 5);
		chk(beats[3], 2);
		chk_mem();
		// byte beats to an odd address; lanes beside them must stay untouched
		copy(12'h400, 12'h501, 4);
		copy(12'h500, 12'h500, 1);
		copy(12'h505, 12'h505, 1);
		copy(12'h600, 12'h700, 8);
		first_ch = -1;
		bus(1, 8'h24, 32'h0000_1603);
		bus(1, 8'h28, 32'h0000_0101);
		periph_trig[22] <= 1'b1;
		evt_trig[2] <= 1'b1;
		@(posedge clk);
		periph_trig <= '0;
		evt_trig <= '0;
		for (int i = 0; i < 4000 && (beats[1] < 4 || beats[2] < 2); i++) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(first_ch, 1);
		chk(beats[1], 4);
		chk(beats[2], 2);
		chk_mem();
		bus(0, 8'h34, 0);
		chk(q & 32'h2000_0000, 32'h2000_0000);
		end_sim();
	end
	initial begin
		#100000;
		err_total++;
		end_sim();
	end
endmodule
